// File: logic/ccrb_top.sv
// Configuration register bank with processor control and result registers.
//
// Overview of operation
// - There are 48 configuration registers, each one byte wide.
// - Four special function registers follow the configuration set.
// - The last configuration register holds only the run bit, which enables front end and processor.
// - Each configuration write updates register and RAM mirror together and can be read back.
// - The processor reads 64 I/O status bits and drives 16 of them to the general purpose pins.
// - The processor runs from an internal clock of about 60 MHz.
// - A firmware command halts the processor clock to save power.
// - A halted processor resumes on a general purpose pin signal or end of measurement.
// - Raw and computed results live in RAM while the program lives in non-volatile memory.
// - At minimum the processor copies raw time values unchanged into the read registers.
// - Read register contents are whatever firmware writes, with no fixed format.
//
// The strobed register port was left to the implementer.
module ccrb_top #(
	parameter int CFG_COUNT = ccrb_pkg::CCRB_CFG_COUNT,
	parameter int IO_BITS = ccrb_pkg::CCRB_IO_BITS,
	parameter int IO_OUT_BITS = ccrb_pkg::CCRB_IO_OUT_BITS
) (
	input wire logic SYS_CLK_I, // 20 MHz system clock.
	input wire logic RST_N_I, // Asynchronous reset, active low.
	input wire logic [7:0] ADDR_I, // Register address.
	input wire logic [7:0] WDATA_I, // Register write data.
	input wire logic WR_I, // Write strobe.
	input wire logic RD_I, // Read strobe.
	output logic [7:0] RDATA_O, // Read data, one cycle after strobe.
	input wire logic [ccrb_pkg::CCRB_IO_BITS-1:0] IO_STATUS_I, // Status bits seen by core.
	input wire logic GPIO_WAKE_I, // General purpose pin wake signal.
	input wire logic MEAS_DONE_I, // End of measurement pulse.
	input wire logic [31:0] RAW_TIME_I, // Raw time value from converters.
	input wire logic [1:0] RAW_INDEX_I, // Result slot of the raw value.
	input wire logic RAW_VALID_I, // Raw value valid pulse.
	input wire logic HALT_CMD_I, // Firmware halt command pulse.
	input wire ccrb_pkg::ccrb_result_t FW_RESULT_I, // Firmware result write.
	input wire logic PASSTHRU_I, // Minimal firmware: copy raw values.
	output logic FRONTEND_RUN_CONTROL_O, // Front end enable.
	output logic CORE_CLK_EN_O, // Processor clock enable.
	output logic [ccrb_pkg::CCRB_IO_OUT_BITS-1:0] GPIO_OUT_O, // Processor driven I/O bits.
	output logic [12:0] CAP_SAMPLE_AVERAGE_COUNT_O, // Averaging count.
	output logic [22:0] CONVERSION_PERIOD_O // Conversion period.
);
	import ccrb_pkg::*;

	initial begin
		if (CFG_COUNT != CCRB_CFG_COUNT || IO_BITS != CCRB_IO_BITS ||
			IO_OUT_BITS != CCRB_IO_OUT_BITS) begin
			$error("unsupported register bank geometry");
		end
	end

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [CCRB_CFG_COUNT-1:0][7:0] cfg;
		logic [CCRB_CFG_COUNT-1:0][7:0] mirror;
		logic [CCRB_SFR_COUNT-1:0][7:0] sfr;
		logic [CCRB_RESULT_COUNT-1:0][31:0] result;
		logic [7:0] rdata;
		logic [IO_OUT_BITS-1:0] gpio;
	} ccrb_state_t;

	ccrb_state_t s_r;
	ccrb_state_t s_nxt;
	ccrb_bus_t bus;
	ccrb_core_t core_state;
	logic core_en;

	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
		input int count);
		in_range = (a >= base) && (int'(a) < int'(base) + count);
	endfunction

	ccrb_core_ctrl u_core (
		.clk_i(SYS_CLK_I),
		.rst_n_i(rst_n),
		.run_i(s_r.cfg[CCRB_OFS_RUN][0]),
		.halt_cmd_i(HALT_CMD_I),
		.gpio_wake_i(GPIO_WAKE_I),
		.meas_done_i(MEAS_DONE_I),
		.state_o(core_state),
		.clk_en_o(core_en)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [5:0] sel;
		logic [7:0] rel;
		sel = 6'h00;
		rel = 8'h00;
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		// Configuration writes land in the register and its RAM mirror at once.
		if (bus.wr && in_range(bus.addr, 8'h00, CCRB_CFG_COUNT)) begin
			if (bus.addr == CCRB_OFS_RUN) begin
				s_nxt.cfg[bus.addr[5:0]] = {7'h00, bus.wdata[0]};
				s_nxt.mirror[bus.addr[5:0]] = {7'h00, bus.wdata[0]};
			end else begin
				s_nxt.cfg[bus.addr[5:0]] = bus.wdata;
				s_nxt.mirror[bus.addr[5:0]] = bus.wdata;
			end
		end
		// Only the I/O select SFR is writable; the others show core state, the selected I/O status bit and the select's upper bits.
		if (bus.wr && bus.addr == CCRB_OFS_SFR0 + 8'(CCRB_SFR_IOSEL)) begin
			s_nxt.sfr[CCRB_SFR_IOSEL] = bus.wdata;
		end
		s_nxt.sfr[CCRB_SFR_STATUS] = {5'h00, core_en, core_state};
		sel = s_r.sfr[CCRB_SFR_IOSEL][5:0];
		s_nxt.sfr[CCRB_SFR_IO_LO] = {7'h00, IO_STATUS_I[sel]};
		s_nxt.sfr[CCRB_SFR_IO_HI] = {4'h0, sel[5:2]};
		// The core drives the GPIO bit chosen by sel[3:0] through writes to the CCRB_SFR_IO_HI address while its clock runs.
		if (bus.wr && bus.addr == CCRB_OFS_SFR0 + 8'(CCRB_SFR_IO_HI) && core_en) begin
			s_nxt.gpio[sel[3:0]] = bus.wdata[0];
		end
		// Result slots are written by firmware; raw copy only in passthrough.
		if (core_en && FW_RESULT_I.wr) begin
			s_nxt.result[FW_RESULT_I.index] = FW_RESULT_I.data;
		end else if (core_en && PASSTHRU_I && RAW_VALID_I) begin
			s_nxt.result[RAW_INDEX_I] = RAW_TIME_I;
		end
		if (bus.rd) begin
			rel = bus.addr - CCRB_OFS_RESULT0;
			if (in_range(bus.addr, 8'h00, CCRB_CFG_COUNT)) begin
				s_nxt.rdata = s_r.mirror[bus.addr[5:0]];
			end else if (in_range(bus.addr, CCRB_OFS_SFR0, CCRB_SFR_COUNT)) begin
				s_nxt.rdata = s_r.sfr[bus.addr[1:0]];
			end else if (in_range(bus.addr, CCRB_OFS_RESULT0, 4 * CCRB_RESULT_COUNT)) begin
				s_nxt.rdata = s_r.result[rel[3:2]][8 * rel[1:0] +: 8];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic run_out_r;
	logic core_en_r;
	logic [12:0] avg_r;
	logic [22:0] conv_r;

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			run_out_r <= 1'b0;
			core_en_r <= 1'b0;
			avg_r <= 13'h0000;
			conv_r <= 23'h000000;
		end else begin
			run_out_r <= s_r.cfg[CCRB_OFS_RUN][0];
			core_en_r <= core_en;
			avg_r <= {s_r.cfg[CCRB_OFS_AVG_HIGH][4:0], s_r.cfg[CCRB_OFS_AVG_LOW]};
			conv_r <= {s_r.cfg[CCRB_OFS_CONV_B2][6:0], s_r.cfg[CCRB_OFS_CONV_B1],
				s_r.cfg[CCRB_OFS_CONV_B0]};
		end
	end

	assign RDATA_O = s_r.rdata;
	assign FRONTEND_RUN_CONTROL_O = run_out_r;
	assign CORE_CLK_EN_O = core_en_r;
	assign GPIO_OUT_O = s_r.gpio;
	assign CAP_SAMPLE_AVERAGE_COUNT_O = avg_r;
	assign CONVERSION_PERIOD_O = conv_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence cfg_write_s;
		WR_I && ADDR_I < 8'(CCRB_CFG_COUNT) && ADDR_I != CCRB_OFS_RUN;
	endsequence

	a_cfg_readback: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		cfg_write_s ##1 (RD_I && ADDR_I == $past(ADDR_I)) |=> RDATA_O == $past(WDATA_I, 2))
		else $error("config readback mismatch");
	a_run_only_bit: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		s_r.cfg[CCRB_OFS_RUN][7:1] == 7'h00)
		else $error("run register has extra bits");
	a_run_follows: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(WR_I && ADDR_I == CCRB_OFS_RUN) |-> ##2 FRONTEND_RUN_CONTROL_O == $past(WDATA_I[0], 2))
		else $error("run control did not follow write");
	a_unmapped_zero: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(RD_I && ADDR_I >= 8'h50) |=> RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	a_avg_order: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		CAP_SAMPLE_AVERAGE_COUNT_O[7:0] == $past(s_r.cfg[CCRB_OFS_AVG_LOW]))
		else $error("averaging low byte misplaced");
	a_raw_copy: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(core_en && PASSTHRU_I && RAW_VALID_I && !FW_RESULT_I.wr)
		|=> s_r.result[$past(RAW_INDEX_I)] == $past(RAW_TIME_I))
		else $error("raw value not copied");
	a_fw_result: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		(core_en && FW_RESULT_I.wr) |=> s_r.result[$past(FW_RESULT_I.index)] == $past(FW_RESULT_I.data))
		else $error("firmware result lost");
	a_status_sfr: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		s_r.sfr[CCRB_SFR_STATUS][2] == $past(core_en))
		else $error("status sfr stale");

endmodule

// File: logic/ccrb_pkg.sv
// Package with constants and carrier types of the configuration register bank.
package ccrb_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int CCRB_CFG_COUNT = 48;
	localparam int CCRB_SFR_COUNT = 4;
	localparam logic [7:0] CCRB_OFS_OSC_TUNE = 8'h00;
	localparam logic [7:0] CCRB_OFS_OSC_CTRL = 8'h01;
	localparam logic [7:0] CCRB_OFS_RES_CHARGE = 8'h02;
	localparam logic [7:0] CCRB_OFS_AUX_CHARGE = 8'h03;
	localparam logic [7:0] CCRB_OFS_CAP_MODE = 8'h04;
	localparam logic [7:0] CCRB_OFS_CYCLE_CLK = 8'h05;
	localparam logic [7:0] CCRB_OFS_CAP_PORTS = 8'h06;
	localparam logic [7:0] CCRB_OFS_AVG_LOW = 8'h07;
	localparam logic [7:0] CCRB_OFS_AVG_HIGH = 8'h08;
	localparam logic [7:0] CCRB_OFS_CONV_B0 = 8'h09;
	localparam logic [7:0] CCRB_OFS_CONV_B1 = 8'h0A;
	localparam logic [7:0] CCRB_OFS_CONV_B2 = 8'h0B;
	localparam logic [7:0] CCRB_OFS_DISCH_LOW = 8'h0C;
	localparam logic [7:0] CCRB_OFS_RUN = 8'h2F;
	localparam logic [7:0] CCRB_OFS_SFR0 = 8'h30;
	localparam logic [7:0] CCRB_OFS_RESULT0 = 8'h40;
	localparam int CCRB_RESULT_COUNT = 4;
	localparam logic [7:0] CCRB_CFG_RESET = 8'h00;
	localparam int CCRB_AVG_BITS = 13;
	localparam int CCRB_CONV_BITS = 23;

	// ----------------------------------------
	// Processor control
	// ----------------------------------------
	localparam int CCRB_IO_BITS = 64;
	localparam int CCRB_IO_OUT_BITS = 16;
	localparam int CCRB_CORE_CLK_KHZ = 60000;
	localparam int CCRB_SFR_STATUS = 0;
	localparam int CCRB_SFR_IO_LO = 1;
	localparam int CCRB_SFR_IO_HI = 2;
	localparam int CCRB_SFR_IOSEL = 3;

	typedef enum logic [1:0] {
		CCRB_CORE_STOP = 2'b00,
		CCRB_CORE_RUN = 2'b01,
		CCRB_CORE_HALT = 2'b11
	} ccrb_core_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ccrb_bus_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] index;
		logic wr;
	} ccrb_result_t;

endpackage

// File: logic/ccrb_core_ctrl.sv
// Clock gate control for the embedded processor: run, halt and wake.
module ccrb_core_ctrl (
	input wire logic clk_i, // System clock.
	input wire logic rst_n_i, // Synchronised reset, active low.
	input wire logic run_i, // Front end run control level.
	input wire logic halt_cmd_i, // Firmware halt command pulse.
	input wire logic gpio_wake_i, // General purpose pin wake level.
	input wire logic meas_done_i, // End of measurement pulse.
	output ccrb_pkg::ccrb_core_t state_o, // Processor state.
	output logic clk_en_o // Processor clock enable.
);
	import ccrb_pkg::*;

	typedef struct packed {
		ccrb_core_t st;
		logic en;
	} ccrb_cc_state_t;

	ccrb_cc_state_t s_r;
	ccrb_cc_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			CCRB_CORE_STOP: begin
				if (run_i) begin
					s_nxt.st = CCRB_CORE_RUN;
				end
			end
			CCRB_CORE_RUN: begin
				if (!run_i) begin
					s_nxt.st = CCRB_CORE_STOP;
				end else if (halt_cmd_i) begin
					s_nxt.st = CCRB_CORE_HALT;
				end
			end
			CCRB_CORE_HALT: begin
				if (!run_i) begin
					s_nxt.st = CCRB_CORE_STOP;
				end else if (gpio_wake_i || meas_done_i) begin
					s_nxt.st = CCRB_CORE_RUN;
				end
			end
			default: begin
				s_nxt.st = CCRB_CORE_STOP;
			end
		endcase
		s_nxt.en = (s_nxt.st == CCRB_CORE_RUN);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '{st: CCRB_CORE_STOP, en: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign state_o = s_r.st;
	assign clk_en_o = s_r.en;

	a_halt_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s_r.st == CCRB_CORE_HALT && run_i && (gpio_wake_i || meas_done_i))
		|=> (s_r.st == CCRB_CORE_RUN && clk_en_o))
		else $error("halted core did not wake");
	a_halt_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(s_r.st == CCRB_CORE_RUN && run_i && halt_cmd_i) |=> !clk_en_o)
		else $error("halt command did not stop clock");

endmodule

// File: testbench/ccrb_host_model.sv
// Host model that drives the register bus of the configuration bank.
module ccrb_host_model (
	input wire logic clk_i, // System clock.
	input wire logic [7:0] rdata_i, // Read data from the bank.
	output logic [7:0] addr_o, // Register address.
	output logic [7:0] wdata_o, // Write data.
	output logic wr_o, // Write strobe.
	output logic rd_o // Read strobe.
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Released lines are inverted so that a stale value never looks like a valid one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
	endtask

	// Write followed by a read of the same address on the very next edge, with no gap.
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= wd;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		wdata_o <= ~wd;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
	endtask
endmodule

// File: testbench/test_cdc_config_register_bank.sv
// Self-checking bench for the configuration register bank.
`define CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
		end \
	end

module test_cdc_config_register_bank;
	timeunit 1ns;
	timeprecision 1ns;
	import ccrb_pkg::*;

	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd, gpio_wake, meas_done, raw_valid, halt_cmd, passthru, run_o, clk_en;
	logic [63:0] io_status;
	logic [31:0] raw_time, v, f, g;
	logic [1:0] raw_index;
	ccrb_result_t fw_result;
	logic [15:0] gpio_out;
	logic [12:0] avg;
	logic [22:0] conv;
	logic [7:0] shadow [48];
	logic [3:0] sel;
	int mismatches = 0;
	int cmp_count = 0;

	always #25 sys_clk = ~sys_clk;

	ccrb_host_model u_ccrb_host_model (.clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	ccrb_top u_ccrb_top (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IO_STATUS_I(io_status),
		.GPIO_WAKE_I(gpio_wake), .MEAS_DONE_I(meas_done), .RAW_TIME_I(raw_time),
		.RAW_INDEX_I(raw_index), .RAW_VALID_I(raw_valid), .HALT_CMD_I(halt_cmd),
		.FW_RESULT_I(fw_result), .PASSTHRU_I(passthru), .FRONTEND_RUN_CONTROL_O(run_o),
		.CORE_CLK_EN_O(clk_en), .GPIO_OUT_O(gpio_out), .CAP_SAMPLE_AVERAGE_COUNT_O(avg),
		.CONVERSION_PERIOD_O(conv));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [12:0] avg_of(logic [7:0] lo, logic [7:0] hi);
		return {hi[4:0], lo};
	endfunction

	function automatic logic [22:0] conv_of(logic [7:0] b0, logic [7:0] b1, logic [7:0] b2);
		return {b2[6:0], b1, b0};
	endfunction

	task automatic rd32(input int slot, output logic [31:0] val);
		logic [7:0] b;
		for (int i = 0; i < 4; i++) begin
			u_ccrb_host_model.rd(CCRB_OFS_RESULT0 + 8'(4 * slot + i), b);
			val[8*i+:8] = b;
		end
	endtask

	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#(50 * 5000);
		mismatches++;
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{gpio_wake, meas_done, raw_valid, halt_cmd, passthru} = 5'h00;
		io_status = 64'h0;
		raw_time = 32'h0;
		raw_index = 2'h0;
		fw_result = '0;
		void'($urandom(32'hA9D5));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < CCRB_CFG_COUNT; i++) begin
			u_ccrb_host_model.rd(8'(i), d);
			`CHK(d, CCRB_CFG_RESET)
		end
		for (int i = 0; i < CCRB_CFG_COUNT - 1; i++) begin
			shadow[i] = 8'($urandom);
			u_ccrb_host_model.wr(8'(i), shadow[i]);
		end
		for (int i = 0; i < CCRB_CFG_COUNT - 1; i++) begin
			u_ccrb_host_model.rd(8'(i), d);
			`CHK(d, shadow[i])
		end
		`CHK(avg, avg_of(shadow[7], shadow[8]))
		`CHK(conv, conv_of(shadow[9], shadow[10], shadow[11]))
		// Back-to-back write and read of one register.
		shadow[7] = 8'($urandom);
		u_ccrb_host_model.wr_rd(CCRB_OFS_AVG_LOW, shadow[7], d);
		`CHK(d, shadow[7])
		// Writes outside the map are dropped and unmapped reads return zero.
		u_ccrb_host_model.wr(8'h50, 8'hA5);
		u_ccrb_host_model.rd(8'h50, d);
		`CHK(d, 8'h00)
		u_ccrb_host_model.rd(8'h34, d);
		`CHK(d, 8'h00)
		u_ccrb_host_model.wr(CCRB_OFS_RUN, 8'hFF);
		u_ccrb_host_model.rd(CCRB_OFS_RUN, d);
		`CHK(d, 8'h01)
		repeat (3) @(posedge sys_clk);
		`CHK(run_o, 1'b1)
		`CHK(clk_en, 1'b1)
		u_ccrb_host_model.rd(CCRB_OFS_SFR0, d);
		`CHK(d, {5'h00, 1'b1, CCRB_CORE_RUN})
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			halt_cmd <= 1'b1;
			@(posedge sys_clk);
			halt_cmd <= 1'b0;
			repeat (3) @(posedge sys_clk);
			`CHK(clk_en, 1'b0)
			`CHK(run_o, 1'b1)
			if (k == 0) begin
				gpio_wake <= 1'b1;
			end else begin
				meas_done <= 1'b1;
			end
			@(posedge sys_clk);
			{gpio_wake, meas_done} <= 2'b00;
			repeat (3) @(posedge sys_clk);
			`CHK(clk_en, 1'b1)
		end
		sel = 4'($urandom);
		io_status <= {32'($urandom), 32'($urandom)};
		u_ccrb_host_model.wr(CCRB_OFS_SFR0 + 8'h03, {4'h0, sel});
		u_ccrb_host_model.wr(CCRB_OFS_SFR0 + 8'h02, 8'h01);
		repeat (3) @(posedge sys_clk);
		`CHK(gpio_out, 16'h0001 << sel)
		u_ccrb_host_model.rd(CCRB_OFS_SFR0 + 8'h01, d);
		`CHK(d, {7'h00, io_status[sel]})
		u_ccrb_host_model.rd(CCRB_OFS_SFR0 + 8'h02, d);
		`CHK(d, {6'h00, sel[3:2]})
		// Raw copy alone, then a raw copy and a firmware write hitting one slot together.
		passthru <= 1'b1;
		v = $urandom;
		f = $urandom;
		@(posedge sys_clk);
		raw_time <= v;
		raw_index <= 2'h2;
		raw_valid <= 1'b1;
		@(posedge sys_clk);
		raw_index <= 2'h3;
		fw_result <= '{data: f, index: 2'h3, wr: 1'b1};
		@(posedge sys_clk);
		raw_valid <= 1'b0;
		fw_result.wr <= 1'b0;
		rd32(2, g);
		`CHK(g, v)
		rd32(3, g);
		`CHK(g, f)
		u_ccrb_host_model.wr(CCRB_OFS_RUN, 8'h00);
		repeat (3) @(posedge sys_clk);
		`CHK(run_o, 1'b0)
		`CHK(clk_en, 1'b0)
		results();
	end
endmodule
